//--- src/wrsw_pkg.sv
// Purpose: Shared constants for the warm reset and secure watchdog block.
// Assumes: 100 MHz system clock, 32 kHz hold timebase derived from it.
// Notes:   Offsets are byte addresses on a 32-bit AXI4-Lite register bus.
package wrsw_pkg;
    // -------------------------------------------------------------
    // Clocking and timebase
    // -------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int SLOW_HZ = 32_000;
    localparam int TICK_DIV = CLK_HZ / SLOW_HZ;
    localparam logic [11:0] TICK_LAST = 12'(TICK_DIV - 1);

    // -------------------------------------------------------------
    // Bus geometry and register offsets
    // -------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_HOLD = 8'h00;
    localparam logic [7:0] OFS_SETUP = 8'h04;
    localparam logic [7:0] OFS_SECCTL = 8'h08;
    localparam logic [7:0] OFS_WDCFG = 8'h0C;
    localparam logic [7:0] OFS_WDKICK = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_WDCOUNT = 8'h18;

    // -------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------
    localparam int SEC_FRZ_BIT = 0;
    localparam int WD_DIS_BIT = 0;
    localparam int WD_LOAD_LSB = 16;
    localparam int ST_WARM_BIT = 0;
    localparam int ST_SECURE_BIT = 1;
    localparam int ST_SECLOCK_BIT = 2;
    localparam int ST_WDLOCK_BIT = 3;
    localparam int ST_WDDIS_BIT = 4;
    localparam int ST_FROZEN_BIT = 5;
    localparam int ST_CNT_LSB = 8;

    // -------------------------------------------------------------
    // Reset values and responses
    // -------------------------------------------------------------
    localparam logic [15:0] HOLD_RST = 16'h0001;
    localparam logic [15:0] SETUP_RST = 16'h0000;
    localparam logic [1:0] SECCTL_RST = 2'h0;
    localparam logic [15:0] WD_LOAD_RST = 16'hFFFF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- src/wrsw_wdog.sv
// Purpose: Secure watchdog down-counter on the 32 kHz tick.
// Assumes: tick is a one-cycle pulse; load value is already locked by the caller.
// Notes:   Expiry reloads the counter so the dog keeps biting while unserviced.
`timescale 1ns/10ps
module wrsw_wdog
    import wrsw_pkg::*;
(
    // Clock and power-on reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic tick,
    input wire logic freeze,
    input wire logic wd_off,
    input wire logic kick,
    input wire logic [15:0] load_val,
    // Status
    output logic [15:0] count,
    output logic expire
);
    logic [15:0] count_r;
    logic expire_r;
    wire run = tick && !freeze && !wd_off;
    wire at_zero = (count_r == 16'h0000);

    // Count down; frozen or disabled counts hold still except on a kick and never bite
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_r <= WD_LOAD_RST;
            expire_r <= 1'b0;
        end else begin
            expire_r <= run && at_zero; // [R6]
            if (kick) begin
                count_r <= load_val;
            end else if (run) begin // [R5]
                count_r <= at_zero ? load_val : count_r - 16'h0001;
            end
        end
    end

    assign count = count_r;
    assign expire = expire_r;

    frozen_hold_a: assert property (@(posedge clk) disable iff (rst) // [R5]
        (freeze && !kick) |=> (count_r == $past(count_r)))
        else $error("frozen watchdog count moved");
    bite_cause_a: assert property (@(posedge clk) disable iff (rst) // [R6]
        expire_r |-> $past(tick && at_zero && !freeze && !wd_off))
        else $error("watchdog expired without a running zero count");
endmodule

//--- src/wrsw_top.sv
// Purpose: Warm reset hold sequencer with secure watchdog and write-once secure controls.
// Assumes: RST is power-on reset only; OFF mode and wake-up never reach these flops.
// Notes:   Requests arriving while warm reset is already held are absorbed.
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps

// Notes on behaviour
// R1: Global warm reset holds for ramp delay plus first hold time, in 32 kHz ticks.
// R2: Secure warm reset ignores the ramp delay, holding first hold time only.
// R3: Secure machine or watchdog requests are secure; all others are global.
// R4: Secure control bits are write-once after power-on reset, kept until next one.
// R5: Secure control bit 0 freezes the watchdog count; reset value leaves it running.
// R6: An expired watchdog that is neither frozen nor disabled requests warm reset.
// R7: Secure control bits keep their values through OFF mode and wake-up.
// R8: Watchdog configuration is accepted once; disable sticks until power-on reset.
// R9: Software not using the watchdog disables it once and ignores freeze bits.
// R10: Software may lengthen first hold time to cover supply ramp after OFF mode.
// R11: Hold counter loads on request, decrements per tick, releases at zero.
module wrsw_top
    import wrsw_pkg::*;
(
    // Clock and power-on reset
    input wire logic MCLK,
    input wire logic RST,
    // Reset sources
    input wire logic GLOBAL_RST_REQ,
    input wire logic SECURE_VIOLATION_REQ,
    // Warm reset to consumers
    output logic WARM_RST_OUT,
    // AXI4-Lite write address
    input wire logic [wrsw_pkg::ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    // AXI4-Lite write data
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    // AXI4-Lite write response
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // AXI4-Lite read address
    input wire logic [wrsw_pkg::ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    // AXI4-Lite read data
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY
);
    import wrsw_pkg::*;

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);

    // Word match ignoring byte lane bits
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        hit = (a[ADDR_W-1:2] == ofs[7:2]);
    endfunction

    // Merge a write into an old word under the byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        merge = (old & ~m) | (nw & m);
    endfunction

    // -------------------------------------------------------------
    // 32 kHz tick from the system clock
    // -------------------------------------------------------------
    logic [11:0] tdiv_r;
    logic tick_r;
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            tdiv_r <= 12'h000;
            tick_r <= 1'b0;
        end else begin
            tick_r <= (tdiv_r == TICK_LAST);
            tdiv_r <= (tdiv_r == TICK_LAST) ? 12'h000 : tdiv_r + 12'h001;
        end
    end

    // -------------------------------------------------------------
    // AXI4-Lite slave
    // -------------------------------------------------------------
    logic awrdy_r, wrdy_r, aw_got_r, w_got_r, bvalid_r, arrdy_r, rvalid_r;
    logic [ADDR_W-1:0] wa_r;
    logic [31:0] wd_r, rdata_r;
    logic [3:0] ws_r;
    logic [1:0] bresp_r, rresp_r;
    // Read word is built further down from the register state
    logic [31:0] status_w, rd_word;

    // Decode of the captured write and of the read request
    wire wr_do = aw_got_r && w_got_r && !bvalid_r;
    wire wr_map = hit(wa_r, OFS_HOLD) || hit(wa_r, OFS_SETUP) || hit(wa_r, OFS_SECCTL)
                  || hit(wa_r, OFS_WDCFG) || hit(wa_r, OFS_WDKICK);
    wire rd_take = ARVALID && arrdy_r;
    wire rd_map = hit(ARADDR, OFS_HOLD) || hit(ARADDR, OFS_SETUP) || hit(ARADDR, OFS_SECCTL)
                  || hit(ARADDR, OFS_WDCFG) || hit(ARADDR, OFS_STATUS)
                  || hit(ARADDR, OFS_WDCOUNT);

    // Address and data may arrive in either order; response waits for both
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            {awrdy_r, wrdy_r, arrdy_r} <= 3'b111;
            {aw_got_r, w_got_r, bvalid_r, rvalid_r} <= 4'b0000;
            wa_r <= '0;
            wd_r <= 32'h0000_0000;
            ws_r <= 4'h0;
            bresp_r <= RESP_OKAY;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end else begin
            if (AWVALID && awrdy_r) begin
                wa_r <= AWADDR;
                aw_got_r <= 1'b1;
                awrdy_r <= 1'b0;
            end
            if (WVALID && wrdy_r) begin
                wd_r <= WDATA;
                ws_r <= WSTRB;
                w_got_r <= 1'b1;
                wrdy_r <= 1'b0;
            end
            if (wr_do) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_map ? RESP_OKAY : RESP_SLVERR;
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
            end else if (bvalid_r && BREADY) begin
                bvalid_r <= 1'b0;
                awrdy_r <= 1'b1;
                wrdy_r <= 1'b1;
            end
            if (rd_take) begin
                arrdy_r <= 1'b0;
                rvalid_r <= 1'b1;
                rdata_r <= rd_word;
                rresp_r <= rd_map ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_r && RREADY) begin
                rvalid_r <= 1'b0;
                arrdy_r <= 1'b1;
            end
        end
    end

    // -------------------------------------------------------------
    // Configuration and secure controls
    // -------------------------------------------------------------
    logic [15:0] hold_r, setup_r, wd_load_r;
    logic [1:0] secctl_r;
    logic sec_lock_r, wd_lock_r, wd_off_r;
    wire [31:0] hold_new = merge({16'h0000, hold_r}, wd_r, ws_r);
    wire [31:0] setup_new = merge({16'h0000, setup_r}, wd_r, ws_r);
    wire [31:0] sec_new = merge({30'h0, secctl_r}, wd_r, ws_r);
    wire [31:0] wdcfg_new = merge({wd_load_r, 15'h0000, wd_off_r}, wd_r, ws_r);
    wire sec_wr = wr_do && hit(wa_r, OFS_SECCTL) && !sec_lock_r;
    wire wd_wr = wr_do && hit(wa_r, OFS_WDCFG) && !wd_lock_r;
    wire wd_kick = wr_do && hit(wa_r, OFS_WDKICK);

    // Only power-on reset clears these; OFF mode and wake leave them alone
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            hold_r <= HOLD_RST;
            setup_r <= SETUP_RST;
            secctl_r <= SECCTL_RST; // [R5]
            sec_lock_r <= 1'b0;
            wd_load_r <= WD_LOAD_RST;
            wd_off_r <= 1'b0;
            wd_lock_r <= 1'b0;
        end else begin
            if (wr_do && hit(wa_r, OFS_HOLD)) begin
                hold_r <= hold_new[15:0];
            end
            if (wr_do && hit(wa_r, OFS_SETUP)) begin
                setup_r <= setup_new[15:0];
            end
            if (sec_wr) begin // [R4] [R7]
                secctl_r <= sec_new[1:0];
                sec_lock_r <= 1'b1;
            end
            if (wd_wr) begin // [R8]
                wd_off_r <= wdcfg_new[WD_DIS_BIT];
                wd_load_r <= wdcfg_new[WD_LOAD_LSB +: 16];
                wd_lock_r <= 1'b1;
            end
        end
    end

    // -------------------------------------------------------------
    // Secure watchdog
    // -------------------------------------------------------------
    logic [15:0] wd_count;
    logic wd_expire;
    wrsw_wdog u_wdog (
        .clk(MCLK),
        .rst(RST),
        .tick(tick_r),
        .freeze(secctl_r[SEC_FRZ_BIT]), // [R5]
        .wd_off(wd_off_r),
        .kick(wd_kick),
        .load_val(wd_load_r),
        .count(wd_count),
        .expire(wd_expire)
    );

    // -------------------------------------------------------------
    // Warm reset hold sequencer
    // -------------------------------------------------------------
    logic warm_r, last_sec_r;
    logic [16:0] hcnt_r;
    wire req_sec = SECURE_VIOLATION_REQ || wd_expire; // [R3] [R6]
    wire req_glb = GLOBAL_RST_REQ; // [R3]
    wire req_take = !warm_r && (req_sec || req_glb);
    // Global wins a tie: the longer hold is the safe one
    wire take_sec = req_sec && !req_glb;
    wire [16:0] dur_glb = {1'b0, setup_r} + {1'b0, hold_r}; // [R1]
    wire [16:0] dur_sec = {1'b0, hold_r}; // [R2]

    // Zero or one count still holds until the next tick, so the pulse is never lost
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            warm_r <= 1'b0;
            last_sec_r <= 1'b0;
            hcnt_r <= 17'h00000;
        end else if (req_take) begin
            warm_r <= 1'b1;
            last_sec_r <= take_sec;
            hcnt_r <= take_sec ? dur_sec : dur_glb; // [R11]
        end else if (warm_r && tick_r) begin
            if (hcnt_r <= 17'h00001) begin // [R11]
                warm_r <= 1'b0;
                hcnt_r <= 17'h00000;
            end else begin
                hcnt_r <= hcnt_r - 17'h00001;
            end
        end
    end

    // -------------------------------------------------------------
    // Read mux
    // -------------------------------------------------------------
    always_comb begin
        status_w = 32'h0000_0000;
        status_w[ST_WARM_BIT] = warm_r;
        status_w[ST_SECURE_BIT] = last_sec_r;
        status_w[ST_SECLOCK_BIT] = sec_lock_r;
        status_w[ST_WDLOCK_BIT] = wd_lock_r;
        status_w[ST_WDDIS_BIT] = wd_off_r;
        status_w[ST_FROZEN_BIT] = secctl_r[SEC_FRZ_BIT];
        status_w[ST_CNT_LSB +: 17] = hcnt_r;
    end
    assign rd_word = hit(ARADDR, OFS_HOLD) ? {16'h0000, hold_r} :
                     hit(ARADDR, OFS_SETUP) ? {16'h0000, setup_r} :
                     hit(ARADDR, OFS_SECCTL) ? {30'h0, secctl_r} :
                     hit(ARADDR, OFS_WDCFG) ? {wd_load_r, 15'h0000, wd_off_r} :
                     hit(ARADDR, OFS_STATUS) ? status_w :
                     hit(ARADDR, OFS_WDCOUNT) ? {16'h0000, wd_count} : 32'h0000_0000;

    assign WARM_RST_OUT = warm_r;
    assign AWREADY = awrdy_r;
    assign WREADY = wrdy_r;
    assign BVALID = bvalid_r;
    assign BRESP = bresp_r;
    assign ARREADY = arrdy_r;
    assign RVALID = rvalid_r;
    assign RDATA = rdata_r;
    assign RRESP = rresp_r;

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    global_hold_a: assert property ((req_take && req_glb) |=> // [R1]
        (warm_r && hcnt_r == $past(dur_glb)))
        else $error("global hold not loaded with setup plus hold time");
    secure_hold_a: assert property ((req_take && !req_glb) |=> // [R2]
        (warm_r && hcnt_r == {1'b0, $past(hold_r)}))
        else $error("secure hold not loaded with hold time only");
    source_class_a: assert property ($rose(warm_r) |-> // [R3]
        (last_sec_r == $past(req_sec && !req_glb)))
        else $error("warm reset source classified wrongly");
    secctl_once_a: assert property (sec_lock_r |=> $stable(secctl_r)) // [R4]
        else $error("secure control bits changed after lock");
    secctl_keep_a: assert property (!$past(sec_wr) |-> $stable(secctl_r)) // [R7]
        else $error("secure control bits changed without a write");
    wd_bite_a: assert property ((wd_expire && !warm_r) |=> warm_r) // [R6]
        else $error("watchdog expiry did not start warm reset");
    wd_off_sticky_a: assert property (wd_off_r |=> (wd_off_r && !wd_expire)) // [R8]
        else $error("disabled watchdog woke up");
    hold_release_a: assert property ((warm_r && tick_r && hcnt_r == 17'h00001 // [R11]
        && !req_take) |=> (!warm_r ##1 (!warm_r || $past(req_take))))
        else $error("warm reset not released at count end");
endmodule

//--- dv/wrsw_rst_sink.sv
// Purpose: Reset consumer model that times every warm reset pulse it receives.
// Assumes: Warm reset is an active-high level in the MCLK domain.
// Notes:   Length is the count of MCLK edges that saw the level high.
`timescale 1ns/10ps
module wrsw_rst_sink (
    // Clock
    input wire logic clk,
    // Warm reset from the block
    input wire logic warm_rst,
    // Measurement for the bench
    output int pulses,
    output int last_len
);
    // Log starts empty so the bench can diff counts against a snapshot
    int run_r = 0;
    int pulses_r = 0;
    int len_r = 0;

    // Count while held, latch the length on release; an unknown level counts as low
    always @(posedge clk) begin
        if (warm_rst === 1'b1) begin
            run_r <= run_r + 1;
        end else if (run_r != 0) begin
            len_r <= run_r;
            pulses_r <= pulses_r + 1;
            run_r <= 0;
        end
    end

    assign pulses = pulses_r;
    assign last_len = len_r;
endmodule

//--- dv/testbench.sv
// Purpose: Self-checking bench for warm reset hold lengths and secure watchdog controls.
// Assumes: Hold lengths come from the reset sink model, in MCLK cycles.
// Notes:   Length limits allow for the partial first 32 kHz tick.
`timescale 1ns/10ps
module testbench;
    import wrsw_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic greq = 1'b0;
    logic sreq = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic warm, awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int err_count = 0;
    int n_checks = 0;
    int pulses, last_len;

    // 100 MHz clock
    always #5 mclk = ~mclk;

    wrsw_top dut (
        .MCLK(mclk), .RST(rst), .GLOBAL_RST_REQ(greq), .SECURE_VIOLATION_REQ(sreq),
        .WARM_RST_OUT(warm), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
        .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
        .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready)
    );

    wrsw_rst_sink sink (.clk(mclk), .warm_rst(warm), .pulses(pulses), .last_len(last_len));

    // ----------------------------------------------------------------
    // Reporting
    // ----------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic timeout(input string what);
        err_count++;
        $display("unexpected %s: expected completion, seen timeout", what);
        print_verdict();
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // ----------------------------------------------------------------
    // Register bus; a channel drops valid at the edge that sees its ready
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 100);
        bready <= 1'b0;
        if (n >= 100) timeout("write response");
        chk("write response", 32'(er), 32'(bresp));
    endtask

    task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 100);
        rready <= 1'b0;
        if (n >= 100) timeout("read response");
        chk("read response", 32'(er), 32'(rresp));
        d = rdata;
    endtask

    task automatic chkrd(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        rd(a, RESP_OKAY, d);
        chk(what, exp, d);
    endtask

    // Wait for the sink to log a new release, then judge the held length in ticks
    task automatic wait_release(input int p0, input int nt, input string what);
        int n;
        n = 0;
        while (pulses == p0 && n < (nt + 5) * TICK_DIV) begin
            @(posedge mclk);
            n++;
        end
        if (pulses == p0) timeout(what);
        n_checks++;
        if (last_len <= (nt - 1) * TICK_DIV || last_len > nt * TICK_DIV + 1) begin
            err_count++;
            $display("unexpected %s: expected %0d ticks, seen %0d cycles", what, nt, last_len);
        end
    endtask

    task automatic chk_secure(input logic sec);
        logic [31:0] d;
        rd(OFS_STATUS, RESP_OKAY, d);
        chk("secure flag", 32'(sec), 32'(d[ST_SECURE_BIT]));
    endtask

    // One-cycle request pulse on the chosen source
    task automatic hold_test(input logic sec, input int nt, input string what);
        int p0;
        p0 = pulses;
        @(posedge mclk);
        greq <= ~sec;
        sreq <= sec;
        @(posedge mclk);
        greq <= 1'b0;
        sreq <= 1'b0;
        wait_release(p0, nt, what);
        chk_secure(sec);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_reset_values();
        logic [31:0] d;
        chkrd(OFS_HOLD, 32'(HOLD_RST), "hold time");
        chkrd(OFS_SETUP, 32'(SETUP_RST), "ramp delay");
        chkrd(OFS_SECCTL, 32'h0, "secure bits");
        chkrd(OFS_WDCFG, 32'hFFFF0000, "watchdog config");
        rd(8'h1C, RESP_SLVERR, d);
        wr(OFS_STATUS, 32'hFFFFFFFF, RESP_SLVERR);
        rd(OFS_STATUS, RESP_OKAY, d);
        chk("frozen flag", 32'h0, 32'(d[ST_FROZEN_BIT]));
        $display("test reset_values done");
    endtask

    task automatic test_holds();
        wr(OFS_HOLD, 32'h00000002, RESP_OKAY);
        wr(OFS_SETUP, 32'h00000001, RESP_OKAY);
        hold_test(1'b0, 3, "global hold");
        hold_test(1'b1, 2, "secure hold");
        $display("test holds done");
    endtask

    // Short load so the dog bites soon; the bite is a secure hold of two ticks
    task automatic test_wd_bite();
        int p0;
        wr(OFS_WDCFG, 32'h00030000, RESP_OKAY);
        p0 = pulses;
        wr(OFS_WDKICK, 32'h0, RESP_OKAY);
        wait_release(p0, 2, "watchdog bite");
        chk_secure(1'b1);
        $display("test wd_bite done");
    endtask

    // Unfrozen, the dog would bite within four ticks; five ticks prove the freeze
    task automatic test_freeze();
        logic [31:0] d1, d2;
        int p0, n;
        wr(OFS_SECCTL, 32'h1, RESP_OKAY);
        n = 0;
        while (warm !== 1'b0 && n < 4 * TICK_DIV) begin
            @(posedge mclk);
            n++;
        end
        if (warm !== 1'b0) timeout("warm release before freeze");
        repeat (2) @(posedge mclk);
        p0 = pulses;
        rd(OFS_WDCOUNT, RESP_OKAY, d1);
        repeat (5 * TICK_DIV) @(posedge mclk);
        rd(OFS_WDCOUNT, RESP_OKAY, d2);
        chk("frozen count", d1, d2);
        chk("pulses while frozen", 32'(p0), 32'(pulses));
        wr(OFS_SECCTL, 32'h0, RESP_OKAY);
        chkrd(OFS_SECCTL, 32'h1, "secure bits relock");
        wr(OFS_WDCFG, 32'h00000001, RESP_OKAY);
        chkrd(OFS_WDCFG, 32'h00030000, "watchdog config relock");
        rd(OFS_STATUS, RESP_OKAY, d1);
        chk("status locks", 32'h2E, {26'h0, d1[5:0]});
        $display("test freeze done");
    endtask

    // Fresh power-on, then disable once; re-enable is refused and no bite comes
    task automatic test_wd_disable();
        logic [31:0] d;
        int p0;
        @(posedge mclk);
        rst <= 1'b1;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        chkrd(OFS_SECCTL, 32'h0, "secure bits after power-on");
        wr(OFS_WDCFG, 32'h00010001, RESP_OKAY);
        wr(OFS_WDCFG, 32'h00010000, RESP_OKAY);
        // Kick loads a count of one, so a live dog would bite within two ticks
        wr(OFS_WDKICK, 32'h0, RESP_OKAY);
        p0 = pulses;
        repeat (4 * TICK_DIV) @(posedge mclk);
        chk("pulses while disabled", 32'(p0), 32'(pulses));
        rd(OFS_STATUS, RESP_OKAY, d);
        chk("disabled flag", 32'h1, 32'(d[ST_WDDIS_BIT]));
        $display("test wd_disable done");
    endtask

    // Main sequence: four-cycle power-on reset, then the scenarios
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        test_reset_values();
        test_holds();
        test_wd_bite();
        test_freeze();
        test_wd_disable();
        print_verdict();
    end
endmodule
